// [rtl/mfd_pkg.sv]
// constants, types and shared decode functions of the instruction field decoder
//
// Contract
// - The table access mode selects no change, post-increment, post-decrement or pre-increment of the table pointer on each table read or write.
// - The address operand of a relative branch is a two's complement displacement, and for call, jump and return it is a direct address; return decodes none.
// - A fast select bit of 0 leaves the shadow registers alone, and a 1 copies core registers into them on call or out of them on return.
// - The table pointer is 21 bits wide and the table latch is 8 bits wide.
// - Indexed addressing yields a 7-bit source offset and, where present, a separate 7-bit destination offset.
// - Don't-care bits never change the decoded result.
// - In byte operations the destination bit sends the result to the working accumulator at 0 and to the file register at 1, with an 8-bit file address.
// - The access bit forces the access bank at 0 and lets the bank select register choose the bank at 1.
// - The file-to-file move carries a 12-bit source in word one and a 12-bit destination in word two, whose top nibble is 1111.
// - Bit operations decode a 3-bit bit number within the 8-bit file register.
// - Literal operations decode an 8-bit immediate value.
// - Absolute call and jump build a 20-bit target from bits 7:0 of word one and bits 19:8 of word two, which begins with 1111.
// - Conditional branches take an 8-bit signed displacement from the low byte of their word.
// - A second word reached on its own, known by its top four bits all one, executes as a no-operation.
// - Single-word instructions take one cycle, plus one no-operation cycle when a test is true or the program counter changes;
//   the decoder gives table reads and writes two cycles in every case.
package mfd_pkg;

    localparam int unsigned TP_W   = 21;
    localparam int unsigned TL_W   = 8;
    localparam int unsigned FA_W   = 12;
    localparam int unsigned TGT_W  = 20;
    localparam int unsigned OFF_W  = 7;

    // register byte offsets
    localparam logic [7:0] REG_TBL_PTR = 8'h00;
    localparam logic [7:0] REG_TBL_LAT = 8'h04;
    localparam logic [7:0] REG_CTRL    = 8'h08;
    localparam logic [7:0] REG_STATUS  = 8'h0C;
    localparam logic [7:0] REG_SHADOW  = 8'h10;

    localparam logic [TP_W-1:0] TBL_PTR_RST = 21'h000000;
    localparam logic [TL_W-1:0] TBL_LAT_RST = 8'h00;
    localparam logic            CTRL_EN_RST = 1'h1;
    localparam int unsigned     CTRL_EN_BIT   = 0;
    localparam int unsigned     STAT_PEND_BIT = 0;
    localparam int unsigned     STAT_FMT_LSB  = 4;
    localparam int unsigned     SHD_ACC_LSB   = 0;
    localparam int unsigned     SHD_STA_LSB   = 8;
    localparam int unsigned     SHD_BSR_LSB   = 16;

    // table access modes
    localparam logic [1:0] TM_KEEP    = 2'h0;
    localparam logic [1:0] TM_POSTINC = 2'h1;
    localparam logic [1:0] TM_POSTDEC = 2'h2;
    localparam logic [1:0] TM_PREINC  = 2'h3;

    localparam logic [3:0] SECOND_PREFIX = 4'hF;
    localparam logic [3:0] OP_FILE_MOVE  = 4'hC;
    localparam logic [7:0] OP_ABS_JUMP   = 8'hEF;
    localparam logic [6:0] OP_CALL       = 7'h76;
    localparam logic [8:0] OP_IDX_MOVE   = 9'h1D7;
    localparam logic [4:0] OP_SHORT_JUMP = 5'h1A;
    localparam logic [4:0] OP_COND_JUMP  = 5'h1C;
    localparam logic [14:0] OP_RETURN    = 15'h0009;
    localparam logic [13:0] OP_TBL_READ  = 14'h0002;
    localparam logic [13:0] OP_TBL_WRITE = 14'h0003;
    localparam logic [4:0] OP_LITERAL    = 5'h01;

    typedef enum logic [3:0] {
        FMT_NONE, FMT_BYTE, FMT_BIT, FMT_LIT, FMT_FILE_MOVE, FMT_IDX_MOVE,
        FMT_ABS_JUMP, FMT_CALL, FMT_RETURN, FMT_SHORT_JUMP, FMT_COND_JUMP,
        FMT_TBL_READ, FMT_TBL_WRITE, FMT_SECOND_NOP
    } mfd_fmt_e;

    typedef struct packed {
        mfd_fmt_e         fmt;
        logic [FA_W-1:0]  src_addr;
        logic [FA_W-1:0]  dst_addr;
        logic             dest_file;
        logic             use_bank;
        logic [2:0]       bit_sel;
        logic [7:0]       literal;
        logic [TGT_W-1:0] target;
        logic [TP_W-1:0]  disp;
        logic             fast;
        logic [1:0]       tbl_mode;
        logic [OFF_W-1:0] off_src;
        logic [OFF_W-1:0] off_dst;
        logic [1:0]       cycles;
    } mfd_dec_s;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] status;
        logic [7:0] bank;
    } mfd_core_s;

    function automatic logic is_second(input logic [15:0] w);
        return w[15:12] == SECOND_PREFIX;
    endfunction

    function automatic mfd_fmt_e classify(input logic [15:0] w);
        if (is_second(w))                        return FMT_SECOND_NOP;
        if (w[15:12] == OP_FILE_MOVE)            return FMT_FILE_MOVE;
        if (w[15:8] == OP_ABS_JUMP)              return FMT_ABS_JUMP;
        if (w[15:9] == OP_CALL)                  return FMT_CALL;
        if (w[15:7] == OP_IDX_MOVE)              return FMT_IDX_MOVE;
        if (w[15:11] == OP_SHORT_JUMP)           return FMT_SHORT_JUMP;
        if (w[15:11] == OP_COND_JUMP)            return FMT_COND_JUMP;
        if (w[15:1] == OP_RETURN)                return FMT_RETURN;
        if (w[15:2] == OP_TBL_READ)              return FMT_TBL_READ;
        if (w[15:2] == OP_TBL_WRITE)             return FMT_TBL_WRITE;
        if (w[15:12] >= 4'h7 && w[15:12] <= 4'hB) return FMT_BIT;
        if (w[15:11] == OP_LITERAL)              return FMT_LIT;
        if (w[15:12] >= 4'h1 || w[15:9] != 7'h00) return FMT_BYTE;
        return FMT_NONE;
    endfunction

    function automatic logic two_word(input mfd_fmt_e f);
        return f == FMT_FILE_MOVE || f == FMT_IDX_MOVE || f == FMT_ABS_JUMP || f == FMT_CALL;
    endfunction

    // sign-extends an 11-bit or an 8-bit displacement to pointer width
    function automatic logic [TP_W-1:0] sext_disp(input logic [10:0] v, input logic wide);
        if (wide) return {{10{v[10]}}, v};
        return {{13{v[7]}}, v[7:0]};
    endfunction

    // byte-enable merge of a bus write into a stored word
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

endpackage

// [rtl/mfd_field_extract.sv]
// operand field extraction for one or a pair of instruction words
`timescale 1ns/1ps
module mfd_field_extract
    import mfd_pkg::*;
(
    input  wire logic [15:0] word_i,       // current word
    input  wire logic [15:0] first_i,      // held first word of a pair
    input  wire logic        pair_i,       // word_i completes a pair
    input  wire logic        cond_true_i,  // test of this instruction is true
    output mfd_dec_s         dec_o         // decoded fields
);
    logic [15:0] w1;

    always_comb begin
        w1    = pair_i ? first_i : word_i;
        dec_o = '0;
        dec_o.fmt    = classify(w1);
        dec_o.cycles = 2'd1;
        unique case (dec_o.fmt)
            FMT_BYTE, FMT_BIT: begin
                dec_o.src_addr  = {4'h0, w1[7:0]};
                dec_o.use_bank  = w1[8];
                dec_o.dest_file = (dec_o.fmt == FMT_BYTE) ? w1[9] : 1'b1;
                dec_o.bit_sel   = (dec_o.fmt == FMT_BIT) ? w1[11:9] : 3'h0;
                dec_o.cycles    = cond_true_i ? 2'd2 : 2'd1;
            end
            FMT_LIT:        dec_o.literal = w1[7:0];
            FMT_FILE_MOVE: begin
                dec_o.src_addr = w1[11:0];
                dec_o.dst_addr = word_i[11:0];
                dec_o.cycles   = 2'd2;
            end
            FMT_IDX_MOVE: begin
                dec_o.off_src = w1[6:0];
                dec_o.off_dst = word_i[6:0];
                dec_o.cycles  = 2'd2;
            end
            FMT_ABS_JUMP, FMT_CALL: begin
                dec_o.target = {word_i[11:0], w1[7:0]};
                dec_o.fast   = (dec_o.fmt == FMT_CALL) && w1[8];
                dec_o.cycles = 2'd2;
            end
            FMT_RETURN: begin
                dec_o.fast   = w1[0];
                dec_o.cycles = 2'd2;
            end
            FMT_SHORT_JUMP: begin
                dec_o.disp   = sext_disp(w1[10:0], 1'b1);
                dec_o.cycles = 2'd2;
            end
            FMT_COND_JUMP: begin
                dec_o.disp   = sext_disp({3'h0, w1[7:0]}, 1'b0);
                dec_o.cycles = cond_true_i ? 2'd2 : 2'd1;
            end
            FMT_TBL_READ, FMT_TBL_WRITE: begin
                dec_o.tbl_mode = w1[1:0];
                dec_o.cycles   = 2'd2;
            end
            FMT_SECOND_NOP, FMT_NONE: dec_o.cycles = 2'd1;
            default:        dec_o.cycles = 2'd1;
        endcase
    end
endmodule // mfd_field_extract

// [rtl/mfd_table_unit.sv]
// table pointer and table latch with access-mode update
`timescale 1ns/1ps
module mfd_table_unit
    import mfd_pkg::*;
(
    input  wire logic            clk_sys_i,   // core clock
    input  wire logic            rstn_i,      // async reset, active low
    input  wire logic            op_i,        // table access decoded
    input  wire logic            op_write_i,  // access is a write
    input  wire logic [1:0]      mode_i,      // pointer access mode
    input  wire logic            ld_ptr_i,    // bus load of pointer
    input  wire logic [TP_W-1:0] ld_ptr_val_i,// pointer load value
    input  wire logic            ld_lat_i,    // bus load of latch
    input  wire logic [TL_W-1:0] ld_lat_val_i,// latch load value
    input  wire logic            rd_valid_i,  // program memory read data valid
    input  wire logic [TL_W-1:0] rd_data_i,   // program memory read data
    output logic      [TP_W-1:0] ptr_o,       // table pointer
    output logic      [TL_W-1:0] latch_o,     // table latch
    output logic      [TP_W-1:0] addr_o,      // program memory address
    output logic                 mem_rd_o,    // read strobe
    output logic                 mem_wr_o     // write strobe, data is latch_o
);
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ptr_o  <= TBL_PTR_RST;
            addr_o <= TBL_PTR_RST;
        end else if (op_i) begin
            unique case (mode_i)
                TM_KEEP:    ptr_o <= ptr_o;
                TM_POSTINC: ptr_o <= ptr_o + 21'h1;
                TM_POSTDEC: ptr_o <= ptr_o - 21'h1;
                TM_PREINC:  ptr_o <= ptr_o + 21'h1;
            endcase
            addr_o <= (mode_i == TM_PREINC) ? ptr_o + 21'h1 : ptr_o;
        end else if (ld_ptr_i) begin
            ptr_o <= ld_ptr_val_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mem_rd_o <= 1'b0;
            mem_wr_o <= 1'b0;
        end else begin
            mem_rd_o <= op_i && !op_write_i;
            mem_wr_o <= op_i && op_write_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i)          latch_o <= TBL_LAT_RST;
        else if (rd_valid_i)  latch_o <= rd_data_i;
        else if (ld_lat_i)    latch_o <= ld_lat_val_i;
    end
endmodule // mfd_table_unit

// [rtl/mfd_decoder.sv]
// instruction field decoder top: word pairing, shadow save/restore, register slave
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module mfd_decoder
    import mfd_pkg::*;
(
    input  wire logic            clk_sys_i,          // core clock, 40 MHz
    input  wire logic            rstn_i,             // async reset, active low
    input  wire logic            instr_valid_i,      // instruction word present
    input  wire logic [15:0]     instr_i,            // fetched instruction word
    input  wire logic            cond_true_i,        // conditional test is true
    input  mfd_core_s            core_i,             // live accumulator, status, bank
    input  wire logic            tbl_rd_valid_i,     // table read data valid
    input  wire logic [TL_W-1:0] tbl_rd_data_i,      // table read data
    output logic                 dec_valid_o,        // decoded fields valid, pulse
    output mfd_dec_s             dec_o,              // decoded fields
    output logic                 shadow_save_o,      // shadow captured, pulse
    output logic                 restore_valid_o,    // restore core regs, pulse
    output mfd_core_s            restore_o,          // values to restore
    output logic      [TP_W-1:0] tbl_addr_o,         // table program memory address
    output logic                 tbl_rd_o,           // table read strobe
    output logic                 tbl_wr_o,           // table write strobe
    output logic      [TL_W-1:0] tbl_wdata_o,        // table write data
    input  wire logic [7:0]      avs_address_i,      // register byte address
    input  wire logic            avs_read_i,         // read request
    input  wire logic            avs_write_i,        // write request
    input  wire logic [31:0]     avs_writedata_i,    // write data
    input  wire logic [3:0]      avs_byteenable_i,   // byte enables
    output logic      [31:0]     avs_readdata_o,     // read data
    output logic                 avs_waitrequest_o   // wait request
);
    typedef enum logic {ST_SINGLE, ST_WAIT_SECOND} mfd_seq_e;

    mfd_seq_e    seq_q;
    logic [15:0] first_q;
    logic        enable_q;
    mfd_core_s   shadow_q;
    mfd_dec_s    ext;
    mfd_fmt_e    fresh_fmt;
    logic        take;
    logic        pair;
    logic        start_pair;
    logic        issue;
    logic        bus_wr;
    logic        bus_rd;
    logic [TP_W-1:0] ptr;
    logic [31:0]     ptr_wr;

    assign take       = instr_valid_i && enable_q;
    // a second word only pairs when a first word is held; alone it is a no-op
    assign pair       = (seq_q == ST_WAIT_SECOND) && is_second(instr_i);
    assign fresh_fmt  = classify(instr_i);
    assign start_pair = take && !pair && two_word(fresh_fmt);
    assign issue      = take && !start_pair;
    assign bus_wr     = avs_write_i && !avs_waitrequest_o;
    assign bus_rd     = avs_read_i && avs_waitrequest_o;
    // byte-enable merge of a bus write into the current pointer
    assign ptr_wr     = be_merge({11'h0, ptr}, avs_writedata_i, avs_byteenable_i);

    mfd_field_extract u_extract (
        .word_i      (instr_i),
        .first_i     (first_q),
        .pair_i      (pair),
        .cond_true_i (cond_true_i),
        .dec_o       (ext)
    );

    mfd_table_unit u_table (
        .clk_sys_i    (clk_sys_i),
        .rstn_i       (rstn_i),
        .op_i         (issue && (ext.fmt == FMT_TBL_READ || ext.fmt == FMT_TBL_WRITE)),
        .op_write_i   (ext.fmt == FMT_TBL_WRITE),
        .mode_i       (ext.tbl_mode),
        .ld_ptr_i     (bus_wr && avs_address_i == REG_TBL_PTR),
        .ld_ptr_val_i (ptr_wr[TP_W-1:0]),
        .ld_lat_i     (bus_wr && avs_address_i == REG_TBL_LAT && avs_byteenable_i[0]),
        .ld_lat_val_i (avs_writedata_i[TL_W-1:0]),
        .rd_valid_i   (tbl_rd_valid_i),
        .rd_data_i    (tbl_rd_data_i),
        .ptr_o        (ptr),
        .latch_o      (tbl_wdata_o),
        .addr_o       (tbl_addr_o),
        .mem_rd_o     (tbl_rd_o),
        .mem_wr_o     (tbl_wr_o)
    );

    // word pairing sequence
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seq_q   <= ST_SINGLE;
            first_q <= 16'h0000;
        end else if (take) begin
            if (start_pair) begin
                seq_q   <= ST_WAIT_SECOND;
                first_q <= instr_i;
            end else begin
                seq_q <= ST_SINGLE;
            end
        end
    end

    // decoded field register
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dec_valid_o <= 1'b0;
            dec_o       <= '0;
        end else begin
            dec_valid_o <= issue;
            if (issue) dec_o <= ext;
        end
    end

    // fast call saves, fast return restores
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shadow_q        <= '0;
            shadow_save_o   <= 1'b0;
            restore_valid_o <= 1'b0;
            restore_o       <= '0;
        end else begin
            shadow_save_o   <= issue && ext.fmt == FMT_CALL && ext.fast;
            restore_valid_o <= issue && ext.fmt == FMT_RETURN && ext.fast;
            if (issue && ext.fmt == FMT_CALL && ext.fast) begin
                shadow_q <= core_i;
            end
            if (issue && ext.fmt == FMT_RETURN && ext.fast) begin
                restore_o <= shadow_q;
            end
        end
    end

    // avalon slave: one wait cycle per access
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) avs_waitrequest_o <= 1'b1;
        else         avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            enable_q <= CTRL_EN_RST;
        end else if (bus_wr && avs_address_i == REG_CTRL && avs_byteenable_i[0]) begin
            enable_q <= avs_writedata_i[CTRL_EN_BIT];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            avs_readdata_o <= 32'h00000000;
        end else if (bus_rd) begin
            avs_readdata_o <= 32'h00000000;
            unique case (avs_address_i)
                REG_TBL_PTR: avs_readdata_o[TP_W-1:0] <= ptr;
                REG_TBL_LAT: avs_readdata_o[TL_W-1:0] <= tbl_wdata_o;
                REG_CTRL:    avs_readdata_o[CTRL_EN_BIT] <= enable_q;
                REG_STATUS: begin
                    avs_readdata_o[STAT_PEND_BIT]        <= seq_q == ST_WAIT_SECOND;
                    avs_readdata_o[STAT_FMT_LSB +: 4]    <= dec_o.fmt;
                end
                REG_SHADOW: begin
                    avs_readdata_o[SHD_ACC_LSB +: 8] <= shadow_q.acc;
                    avs_readdata_o[SHD_STA_LSB +: 8] <= shadow_q.status;
                    avs_readdata_o[SHD_BSR_LSB +: 8] <= shadow_q.bank;
                end
                default:     avs_readdata_o <= 32'h00000000;
            endcase
        end
    end
endmodule // mfd_decoder

// [bench/mfd_decoder_checker.sv]
// concurrent checks on the decoder top ports
`timescale 1ns/1ps
module mfd_decoder_checker
    import mfd_pkg::*;
(
    input wire logic        clk_sys_i,         // core clock
    input wire logic        rstn_i,            // async reset, active low
    input wire logic        cond_true_i,       // test is true
    input wire logic [15:0] instr_i,           // instruction word
    input wire logic        avs_read_i,        // bus read
    input wire logic        avs_write_i,       // bus write
    input logic             dec_valid_o,       // decode pulse
    input mfd_dec_s         dec_o,             // decoded fields
    input logic             restore_valid_o,   // restore pulse
    input logic             tbl_rd_o,          // table read strobe
    input logic             tbl_wr_o,          // table write strobe
    input logic             avs_waitrequest_o  // wait request
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    sequence ack_s;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    bus_ack_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> ack_s)
        else $error("bus answer wrong");
    tbl_read_a: assert property (tbl_rd_o |-> dec_valid_o && dec_o.fmt == FMT_TBL_READ)
        else $error("table read strobe wrong");
    tbl_write_a: assert property (tbl_wr_o |-> dec_valid_o && dec_o.fmt == FMT_TBL_WRITE)
        else $error("table write strobe wrong");
    slow_ret_a: assert property (dec_valid_o && dec_o.fmt == FMT_RETURN && !dec_o.fast
        |-> !restore_valid_o) else $error("restore without fast bit");
    byte_dest_a: assert property (dec_valid_o && dec_o.fmt == FMT_BYTE |->
        dec_o.dest_file == $past(instr_i[9]) && dec_o.use_bank == $past(instr_i[8]))
        else $error("byte dest or bank wrong");
    bit_sel_a: assert property (dec_valid_o && dec_o.fmt == FMT_BIT |->
        dec_o.bit_sel == $past(instr_i[11:9])) else $error("bit number wrong");
    lit_val_a: assert property (dec_valid_o && dec_o.fmt == FMT_LIT |->
        dec_o.literal == $past(instr_i[7:0])) else $error("literal wrong");
    jump_hi_a: assert property (dec_valid_o && dec_o.fmt == FMT_ABS_JUMP |->
        dec_o.target[19:8] == $past(instr_i[11:0])) else $error("jump target wrong");
    move_dst_a: assert property (dec_valid_o && dec_o.fmt == FMT_FILE_MOVE |->
        dec_o.dst_addr == $past(instr_i[11:0]) && $past(instr_i[15:12]) == 4'hF)
        else $error("move destination wrong");
    short_disp_a: assert property (dec_valid_o && dec_o.fmt == FMT_SHORT_JUMP |->
        dec_o.disp == {{10{$past(instr_i[10])}}, $past(instr_i[10:0])})
        else $error("short displacement wrong");
    cond_disp_a: assert property (dec_valid_o && dec_o.fmt == FMT_COND_JUMP |->
        dec_o.disp == {{13{$past(instr_i[7])}}, $past(instr_i[7:0])})
        else $error("branch displacement wrong");
    one_cycle_a: assert property (dec_valid_o && dec_o.fmt == FMT_BYTE && !$past(cond_true_i)
        |-> dec_o.cycles == 2'h1) else $error("cycle count wrong");
endmodule // mfd_decoder_checker
bind mfd_decoder mfd_decoder_checker mfd_decoder_checker_i (.clk_sys_i, .rstn_i, .cond_true_i,
    .instr_i, .avs_read_i, .avs_write_i, .dec_valid_o, .dec_o, .restore_valid_o, .tbl_rd_o,
    .tbl_wr_o, .avs_waitrequest_o);

// [bench/test_mfd_decoder.sv]
// self-checking bench for the instruction field decoder
`timescale 1ns/1ps
module test_mfd_decoder;
    import mfd_pkg::*;
    logic            clk_sys_i = 0, rstn_i = 0, instr_valid_i = 0, cond_true_i = 0;
    logic            tbl_rd_valid_i = 0, avs_read_i = 0, avs_write_i = 0, saw_save = 0, saw_rest = 0;
    logic            dec_valid_o, shadow_save_o, restore_valid_o, tbl_rd_o, tbl_wr_o, avs_waitrequest_o;
    logic [15:0]     instr_i = '0;
    logic [TL_W-1:0] tbl_rd_data_i = '0, tbl_wdata_o;
    logic [7:0]      avs_address_i = '0;
    logic [31:0]     avs_writedata_i = '0, avs_readdata_o, rd;
    logic [3:0]      avs_byteenable_i = 4'hF;
    logic [TP_W-1:0] tbl_addr_o;
    mfd_core_s       core_i = '0, restore_o;
    mfd_dec_s        dec_o;
    int              num_errors = 0, total_checks = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        if (shadow_save_o === 1'b1) saw_save <= 1'b1;
        if (restore_valid_o === 1'b1) saw_rest <= 1'b1;
    end
    mfd_decoder mfd_decoder_i (.clk_sys_i, .rstn_i, .instr_valid_i, .instr_i, .cond_true_i, .core_i,
        .tbl_rd_valid_i, .tbl_rd_data_i, .dec_valid_o, .dec_o, .shadow_save_o, .restore_valid_o,
        .restore_o, .tbl_addr_o, .tbl_rd_o, .tbl_wr_o, .tbl_wdata_o, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o);
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // one word per call, decode result visible on return
    task automatic op(input logic [15:0] w, input logic c = 1'b0);
        @(posedge clk_sys_i);
        instr_i <= w; cond_true_i <= c; instr_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        instr_valid_i <= 1'b0;
        @(negedge clk_sys_i);
    endtask
    task automatic bw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        avs_address_i <= a; avs_writedata_i <= d; avs_write_i <= 1'b1;
        do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
    endtask
    task automatic br(input logic [7:0] a);
        @(posedge clk_sys_i);
        avs_address_i <= a; avs_read_i <= 1'b1;
        do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o; avs_read_i <= 1'b0;
    endtask
    task automatic t_regs;
        br(REG_CTRL); chk("ctrl", rd, 32'h1);
        br(REG_TBL_PTR); chk("ptr", rd, 32'h0);
        bw(REG_TBL_PTR, 32'hFFFFFFFF); br(REG_TBL_PTR); chk("ptr", rd, 32'h001FFFFF);
        bw(REG_TBL_LAT, 32'h1FF); br(REG_TBL_LAT); chk("latch", rd, 32'hFF);
        br(8'h40); chk("unmapped", rd, 32'h0);
    endtask
    task automatic t_fields;
        op(16'h27A5); chk("dest", dec_o.dest_file, 1); chk("bank", dec_o.use_bank, 1);
        chk("cyc", dec_o.cycles, 1);
        op(16'h245A, 1'b1); chk("dest", dec_o.dest_file, 0); chk("bank", dec_o.use_bank, 0);
        chk("cyc", dec_o.cycles, 2);
        op(16'h8A33); chk("bit", dec_o.bit_sel, 5);
        op(16'h0E7F); chk("lit", dec_o.literal, 32'h7F);
        op(16'hF123); chk("fmt", dec_o.fmt, FMT_SECOND_NOP);
    endtask
    task automatic t_pairs;
        op(16'hC123); chk("valid", dec_valid_o, 0);
        br(REG_STATUS); chk("status", rd, 32'hD1);
        op(16'hF456);
        chk("src", dec_o.src_addr, 32'h123); chk("dst", dec_o.dst_addr, 32'h456);
        op(16'hEF34); op(16'hF0AB); chk("tgt", dec_o.target, 32'h0AB34);
        for (int i = 0; i < 2; i++) begin
            op(16'hEBAA); op(i == 0 ? 16'hF015 : 16'hFF95);
            chk("offs", dec_o.off_src, 32'h2A); chk("offd", dec_o.off_dst, 32'h15);
        end
    endtask
    task automatic t_branch;
        op(16'hD7FF); chk("disp", dec_o.disp, 32'h1FFFFF);
        op(16'hD400); chk("disp", dec_o.disp, 32'h1FFC00);
        op(16'hE380, 1'b1); chk("disp", dec_o.disp, 32'h1FFF80); chk("cyc", dec_o.cycles, 2);
        op(16'hE37F); chk("disp", dec_o.disp, 32'h7F); chk("cyc", dec_o.cycles, 1);
    endtask
    task automatic t_fast;
        @(posedge clk_sys_i);
        core_i <= '{acc: 8'hAA, status: 8'h55, bank: 8'h0F};
        op(16'hED12); op(16'hF345); chk("fast", dec_o.fast, 1);
        br(REG_SHADOW); chk("save", saw_save, 1); chk("shadow", rd, 32'h000F55AA);
        core_i <= '0; saw_rest <= 1'b0;
        op(16'h0013); chk("fmt", dec_o.fmt, FMT_RETURN);
        @(posedge clk_sys_i); @(negedge clk_sys_i);
        chk("rest", saw_rest, 1); chk("rval", restore_o, 32'hAA550F);
        op(16'h0012); chk("fast", dec_o.fast, 0); chk("rest", restore_valid_o, 0);
        saw_save <= 1'b0;
        op(16'hEC00); op(16'hF000); br(REG_SHADOW);
        chk("save", saw_save, 0); chk("shadow", rd, 32'h000F55AA);
    endtask
    task automatic t_table;
        logic [15:0] w [4] = '{16'h0009, 16'h000A, 16'h000B, 16'h0008};
        logic [20:0] ad [4] = '{21'h10, 21'h11, 21'h11, 21'h11};
        logic [20:0] pn [4] = '{21'h11, 21'h10, 21'h11, 21'h11};
        bw(REG_TBL_PTR, 32'h10);
        for (int i = 0; i < 4; i++) begin
            op(w[i]); chk("rds", tbl_rd_o, 1); chk("addr", tbl_addr_o, ad[i]);
            br(REG_TBL_PTR); chk("ptr", rd, pn[i]);
        end
        @(posedge clk_sys_i); tbl_rd_valid_i <= 1'b1; tbl_rd_data_i <= 8'h5C;
        @(posedge clk_sys_i); tbl_rd_valid_i <= 1'b0;
        op(16'h000C); chk("wrs", tbl_wr_o, 1); chk("wdat", tbl_wdata_o, 32'h5C);
        bw(REG_CTRL, 32'h0); op(16'h0E11); chk("off", dec_valid_o, 0); bw(REG_CTRL, 32'h1);
    endtask
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        t_regs; t_fields; t_pairs; t_branch; t_fast; t_table;
        test_done;
    end
    initial begin
        #50us;
        num_errors++;
        test_done;
    end
endmodule // test_mfd_decoder
